/* File: verilog/odtx_cfg.svh */
// timing, latency and reset constants for the async odt transition link
`ifndef ODTX_CFG_SVH
`define ODTX_CFG_SVH
`define ODTX_CLK_PS 40000
`define ODTX_TAONPD_MIN_PS 2000
`define ODTX_TAONPD_MAX_PS 8500
`define ODTX_TAOFPD_MIN_PS 2000
`define ODTX_TAOFPD_MAX_PS 8500
`define ODTX_CWL 5
`define ODTX_AL 0
`define ODTX_WL (`ODTX_AL + `ODTX_CWL)
`define ODTX_ODTL (`ODTX_WL - 2)
`define ODTX_TANPD (`ODTX_WL - 1)
`define ODTX_TCPDED_CK 1
`define ODTX_TRFC_CK 16
`define ODTX_TXPDLL_CK 10
`define ODTX_CK_HALF 4
`define ODTX_A12_RST 1'b0
`define ODTX_CNT_W 8
`endif

/* File: verilog/odtx_pkg.sv */
// types and shared helpers for the async odt transition link
package odtx_pkg;
	typedef enum logic [1:0] {
		CMD_NOP = 2'h0,
		CMD_REF = 2'h1,
		CMD_MRS = 2'h2,
		CMD_RW = 2'h3
	} odtx_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PRE_PD = 3'h1,
		ST_ENTRY_TR = 3'h3,
		ST_PD = 3'h2,
		ST_PRE_EXIT = 3'h6,
		ST_EXIT_TR = 3'h4
	} odtx_ctl_st_t;

	function automatic logic [7:0] odtx_max(input logic [7:0] a, input logic [7:0] b);
		odtx_max = (a > b) ? a : b;
	endfunction : odtx_max
endpackage : odtx_pkg

/* File: verilog/odtx_link_if.sv */
// link between the memory controller end and the dram termination end
`timescale 1ns/10ps
interface odtx_link_if;
	logic ck;
	logic cke;
	logic odt;
	odtx_pkg::odtx_cmd_t cmd;
	logic a12;

	modport ctl (output ck, output cke, output odt, output cmd, output a12);
	modport dev (input ck, input cke, input odt, input cmd, input a12);
endinterface : odtx_link_if

/* File: verilog/odtx_dev_end.sv */
// dram end: termination control with sync and async odt modes
`timescale 1ns/10ps
`include "odtx_cfg.svh"
module odtx_dev_end (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	odtx_link_if.dev lnk,
	output logic rtt_on,
	output logic rtt_async,
	output logic trans_win,
	output logic pd_state,
	output logic dll_frozen
);
	localparam int ON_MIN_CYC = (`ODTX_TAONPD_MIN_PS + `ODTX_CLK_PS - 1) / `ODTX_CLK_PS;
	localparam int ON_MAX_RAW = `ODTX_TAONPD_MAX_PS / `ODTX_CLK_PS;
	localparam int ON_MAX_CYC = (ON_MAX_RAW < 1) ? 1 : ON_MAX_RAW;
	localparam int OFF_MIN_CYC = (`ODTX_TAOFPD_MIN_PS + `ODTX_CLK_PS - 1) / `ODTX_CLK_PS;
	localparam int OFF_MAX_RAW = `ODTX_TAOFPD_MAX_PS / `ODTX_CLK_PS;
	localparam int OFF_MAX_CYC = (OFF_MAX_RAW < 1) ? 1 : OFF_MAX_RAW;
	// the clock is far coarser than the window, so the least legal delay is used
	localparam int ON_CYC = (ON_MIN_CYC < 1) ? 1 : ON_MIN_CYC;
	localparam int OFF_CYC = (OFF_MIN_CYC < 1) ? 1 : OFF_MIN_CYC;
	localparam int ODTL = `ODTX_ODTL;
	localparam int B_CK = 5;
	localparam int B_CKE = 4;
	localparam int B_ODT = 3;

	logic [5:0] link_in;
	logic [5:0] sy1_q;
	logic [5:0] sy2_q;
	logic [5:0] sy3_q;
	logic [5:0] flt_q;
	logic ck_prev_q;
	logic ck_rise;
	logic cke_s;
	logic odt_s;
	odtx_pkg::odtx_cmd_t cmd_s;
	logic a12_s;
	logic cke_reg_q;
	logic a12_q;
	logic frz_q;
	logic pd_q;
	logic async_q;
	logic [ODTL-1:0] pipe_q;
	logic [`ODTX_CNT_W-1:0] rfc_q;
	logic [`ODTX_CNT_W-1:0] tr_cnt_q;
	logic tr_q;
	logic [`ODTX_CNT_W-1:0] acnt_q;
	logic rtt_q;
	logic pd_entry;
	logic pd_exit;

	assign link_in = {lnk.ck, lnk.cke, lnk.odt, lnk.cmd, lnk.a12};

	// three-stage sampling; a level is taken only once stages two and three agree
	always_ff @(posedge clk_sys) begin
		// cke idles high, so its stages start high and no false entry edge follows reset
		if (rst) begin
			sy1_q <= 6'h10;
			sy2_q <= 6'h10;
			sy3_q <= 6'h10;
			flt_q <= 6'h10;
		end else if (ce) begin
			sy1_q <= link_in;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			flt_q <= (flt_q & (sy2_q ^ sy3_q)) | (sy3_q & ~(sy2_q ^ sy3_q));
		end
	end

	assign cke_s = flt_q[B_CKE];
	assign odt_s = flt_q[B_ODT];
	assign cmd_s = odtx_pkg::odtx_cmd_t'(flt_q[2:1]);
	assign a12_s = flt_q[0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ck_prev_q <= 1'b0;
		end else if (ce) begin
			ck_prev_q <= flt_q[B_CK];
		end
	end

	assign ck_rise = flt_q[B_CK] & ~ck_prev_q;
	assign pd_entry = ck_rise & cke_reg_q & ~cke_s;
	assign pd_exit = ck_rise & ~cke_reg_q & cke_s;

	// cke as registered on the link clock, and the power-down state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cke_reg_q <= 1'b1;
			pd_q <= 1'b0;
		end else if (ce && ck_rise) begin
			cke_reg_q <= cke_s;
			pd_q <= ~cke_s;
		end
	end

	// command receivers are off in power-down, so a mode register set there is dropped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			a12_q <= `ODTX_A12_RST;
			frz_q <= ~`ODTX_A12_RST;
		end else if (ce && ck_rise && cke_s && cke_reg_q && cmd_s == odtx_pkg::CMD_MRS) begin
			a12_q <= a12_s;
			frz_q <= ~a12_s;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rfc_q <= '0;
		end else if (ce && ck_rise) begin
			if (cke_s && cke_reg_q && cmd_s == odtx_pkg::CMD_REF) begin
				rfc_q <= 8'(`ODTX_TRFC_CK);
			end else if (rfc_q != '0) begin
				rfc_q <= rfc_q - 8'h01;
			end
		end
	end

	// transition window: runs from the cke edge through its last counted clock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tr_cnt_q <= '0;
			tr_q <= 1'b0;
		end else if (ce && ck_rise) begin
			if (pd_entry && !a12_q) begin
				tr_cnt_q <= odtx_pkg::odtx_max(tr_cnt_q,
					odtx_pkg::odtx_max(8'(`ODTX_TCPDED_CK), rfc_q));
				tr_q <= 1'b1;
			end else if (pd_exit && !a12_q) begin
				tr_cnt_q <= odtx_pkg::odtx_max(tr_cnt_q, 8'(`ODTX_TXPDLL_CK));
				tr_q <= 1'b1;
			end else if (tr_cnt_q != '0) begin
				tr_cnt_q <= tr_cnt_q - 8'h01;
				tr_q <= 1'b1;
			end else begin
				tr_q <= 1'b0;
			end
		end
	end

	// async timing only while powered down with the dll frozen
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			async_q <= 1'b0;
		end else if (ce) begin
			async_q <= ~cke_reg_q & ~a12_q;
		end
	end

	// synchronous path: odt registered on each link clock, wl-2 stages deep
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pipe_q <= '0;
		end else if (ce && ck_rise) begin
			pipe_q <= {pipe_q[ODTL-2:0], odt_s};
		end
	end

	// async delay counter; odt level is watched only while async timing is on, in frozen power-down
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acnt_q <= '0;
		end else if (ce) begin
			if (!async_q || odt_s == rtt_q) begin
				acnt_q <= '0;
			end else begin
				acnt_q <= acnt_q + 8'h01;
			end
		end
	end

	// a change in flight at a mode switch lands within the merged window
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rtt_q <= 1'b0;
		end else if (ce) begin
			if (async_q) begin
				if (odt_s && !rtt_q && acnt_q >= 8'(ON_CYC - 1)) begin
					rtt_q <= 1'b1;
				end else if (!odt_s && rtt_q && acnt_q >= 8'(OFF_CYC - 1)) begin
					rtt_q <= 1'b0;
				end
			end else if (ck_rise) begin
				rtt_q <= pipe_q[ODTL-1];
			end
		end
	end

	assign rtt_on = rtt_q;
	assign rtt_async = async_q;
	assign trans_win = tr_q;
	assign pd_state = pd_q;
	assign dll_frozen = frz_q;
endmodule : odtx_dev_end

/* File: verilog/odtx_ctl_end.sv */
// controller end: drives ck by division, plans cke around transition periods
`timescale 1ns/10ps
`include "odtx_cfg.svh"
module odtx_ctl_end (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	odtx_link_if.ctl lnk,
	input wire logic pd_req,
	input wire logic odt_req,
	input wire logic cmd_valid,
	input wire odtx_pkg::odtx_cmd_t cmd_code,
	input wire logic cmd_a12,
	output logic cmd_ready,
	output logic pd_active,
	output logic rtt_uncertain
);
	logic [2:0] div_q;
	logic ck_q;
	logic tick;
	logic fall;
	logic rise;
	logic cke_q;
	logic odt_q;
	odtx_pkg::odtx_cmd_t cmd_q;
	logic a12_q;
	logic rdy_q;
	logic pd_act_q;
	logic unc_q;
	logic [`ODTX_CNT_W-1:0] cnt_q;
	logic [`ODTX_CNT_W-1:0] rfc_q;
	odtx_pkg::odtx_ctl_st_t st_q;
	logic take;

	assign tick = (div_q == 3'(`ODTX_CK_HALF - 1));
	assign fall = tick & ck_q;
	assign rise = tick & ~ck_q;
	// commands only from idle with no power-down pending
	assign take = fall & cmd_valid & ~pd_req & (st_q == odtx_pkg::ST_IDLE);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_q <= 3'h0;
			ck_q <= 1'b0;
		end else if (ce) begin
			div_q <= tick ? 3'h0 : div_q + 3'h1;
			ck_q <= tick ? ~ck_q : ck_q;
		end
	end

	// link outputs change on the falling edge so the dram samples them settled
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cke_q <= 1'b1;
			odt_q <= 1'b0;
			cmd_q <= odtx_pkg::CMD_NOP;
			a12_q <= 1'b0;
			rdy_q <= 1'b0;
		end else if (ce) begin
			rdy_q <= take;
			if (fall) begin
				cke_q <= ~(st_q == odtx_pkg::ST_ENTRY_TR || st_q == odtx_pkg::ST_PD
					|| st_q == odtx_pkg::ST_PRE_EXIT);
				odt_q <= odt_req;
				cmd_q <= take ? cmd_code : odtx_pkg::CMD_NOP;
				a12_q <= take ? cmd_a12 : 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rfc_q <= '0;
		end else if (ce && rise) begin
			if (cmd_q == odtx_pkg::CMD_REF) begin
				rfc_q <= 8'(`ODTX_TRFC_CK);
			end else if (rfc_q != '0) begin
				rfc_q <= rfc_q - 8'h01;
			end
		end
	end

	// the lead-in of wl-1 clocks is served before cke moves
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= odtx_pkg::ST_IDLE;
			cnt_q <= '0;
		end else if (ce && rise) begin
			unique case (st_q)
				odtx_pkg::ST_IDLE: begin
					if (pd_req) begin
						st_q <= odtx_pkg::ST_PRE_PD;
						cnt_q <= 8'(`ODTX_TANPD);
					end
				end
				odtx_pkg::ST_PRE_PD: begin
					if (cnt_q <= 8'h01) begin
						st_q <= odtx_pkg::ST_ENTRY_TR;
						cnt_q <= odtx_pkg::odtx_max(8'(`ODTX_TCPDED_CK), rfc_q) + 8'h01;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				odtx_pkg::ST_ENTRY_TR: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (pd_req) begin
						st_q <= odtx_pkg::ST_PD;
					end else begin
						st_q <= odtx_pkg::ST_PRE_EXIT;
						cnt_q <= 8'(`ODTX_TANPD);
					end
				end
				odtx_pkg::ST_PD: begin
					if (!pd_req) begin
						st_q <= odtx_pkg::ST_PRE_EXIT;
						cnt_q <= 8'(`ODTX_TANPD);
					end
				end
				odtx_pkg::ST_PRE_EXIT: begin
					if (cnt_q <= 8'h01) begin
						st_q <= odtx_pkg::ST_EXIT_TR;
						cnt_q <= 8'(`ODTX_TXPDLL_CK + 1);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				odtx_pkg::ST_EXIT_TR: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (pd_req) begin
						st_q <= odtx_pkg::ST_PRE_PD;
						cnt_q <= 8'(`ODTX_TANPD);
					end else begin
						st_q <= odtx_pkg::ST_IDLE;
					end
				end
				default: begin
					st_q <= odtx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			unc_q <= 1'b0;
			pd_act_q <= 1'b0;
		end else if (ce) begin
			unc_q <= (st_q != odtx_pkg::ST_IDLE) && (st_q != odtx_pkg::ST_PD);
			pd_act_q <= (st_q == odtx_pkg::ST_PD);
		end
	end

	assign lnk.ck = ck_q;
	assign lnk.cke = cke_q;
	assign lnk.odt = odt_q;
	assign lnk.cmd = cmd_q;
	assign lnk.a12 = a12_q;
	assign cmd_ready = rdy_q;
	assign pd_active = pd_act_q;
	assign rtt_uncertain = unc_q;
endmodule : odtx_ctl_end

/* File: sim/odtx_link_chk.sv */
// link protocol assertions between the controller end and the dram end
`timescale 1ns/10ps
`include "odtx_cfg.svh"
module odtx_link_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ck,
	input wire logic cke,
	input wire logic odt,
	input wire odtx_pkg::odtx_cmd_t cmd,
	input wire logic a12
);
	// every cke level spans a full wl-1 lead-in, so it lasts at least that many ck periods
	localparam int MIN_RUN = (`ODTX_WL - 1) * 2 * `ODTX_CK_HALF - 1;
	logic cke_q;
	logic [7:0] run_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys) begin
		cke_q <= rst ? 1'b1 : cke;
	end
	always_ff @(posedge clk_sys) begin
		if (rst || cke != cke_q)
			run_q <= 8'h00;
		else if (run_q != 8'hff)
			run_q <= run_q + 8'h01;
	end
	AST_CK_HIGH: assert property ($rose(ck) |=> ck [*3] ##1 !ck)
		else $error("link clock high phase is not four cycles");
	AST_CK_LOW: assert property ($fell(ck) |=> !ck [*3] ##1 ck)
		else $error("link clock low phase is not four cycles");
	AST_CKE_EDGE: assert property ($changed(cke) |-> $fell(ck))
		else $error("cke moved away from a link clock fall");
	AST_ODT_EDGE: assert property ($changed(odt) |-> $fell(ck))
		else $error("odt moved away from a link clock fall");
	AST_CMD_EDGE: assert property ($changed({cmd, a12}) |-> $fell(ck))
		else $error("command moved away from a link clock fall");
	AST_CMD_HOLD: assert property (($changed(cmd) && cmd != odtx_pkg::CMD_NOP) |=> $stable(cmd) [*7])
		else $error("command not held for one link clock period");
	AST_NO_RW_PD: assert property (!cke |-> cmd != odtx_pkg::CMD_RW)
		else $error("read or write issued in power-down");
	AST_CMD_CKE: assert property (cmd != odtx_pkg::CMD_NOP |-> cke)
		else $error("command issued with cke low");
	AST_CKE_LOW_MIN: assert property ($rose(cke) |-> run_q >= MIN_RUN)
		else $error("cke rose before the exit lead-in ran");
	AST_CKE_HIGH_MIN: assert property ($fell(cke) |-> run_q >= MIN_RUN)
		else $error("cke fell before the entry lead-in ran");
endmodule : odtx_link_chk

/* File: sim/odt_async_mode_transition_test.sv */
// self-checking bench: both ends joined by the link, model expectations
`timescale 1ns/10ps
`include "odtx_cfg.svh"
module odt_async_mode_transition_test;
	localparam int CK = 2 * `ODTX_CK_HALF;
	localparam int ODTL = `ODTX_ODTL;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic pd_req = 1'b0;
	logic odt_req = 1'b0;
	logic cmd_valid = 1'b0;
	odtx_pkg::odtx_cmd_t cmd_code = odtx_pkg::CMD_NOP;
	logic cmd_a12 = 1'b0;
	logic cmd_ready, pd_active, rtt_uncertain, rtt_on, rtt_async, trans_win, pd_state, dll_frozen;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 64;
	int gaps = 0;
	int n;
	int m;
	logic exp_frozen = 1'b1;
	logic exp_rtt = 1'b0;
	odtx_link_if lnk ();
	odtx_ctl_end odtx_ctl_end_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .lnk(lnk),
		.pd_req(pd_req), .odt_req(odt_req), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_a12(cmd_a12), .cmd_ready(cmd_ready), .pd_active(pd_active),
		.rtt_uncertain(rtt_uncertain));
	odtx_dev_end odtx_dev_end_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .lnk(lnk),
		.rtt_on(rtt_on), .rtt_async(rtt_async), .trans_win(trans_win), .pd_state(pd_state),
		.dll_frozen(dll_frozen));
	odtx_link_chk odtx_link_chk_i (.clk_sys(clk_sys), .rst(rst), .ck(lnk.ck), .cke(lnk.cke),
		.odt(lnk.odt), .cmd(lnk.cmd), .a12(lnk.a12));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task fail(input string what);
		n_mismatch++;
		$display("MISMATCH at %0t: %s", $time, what);
	endtask : fail
	task chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp)
			fail(what);
	endtask : chk_bit
	task chk_rng(input int got, input int lo, input int hi, input string what);
		compares++;
		if (got < lo || got > hi)
			fail($sformatf("%s took %0d", what, got));
	endtask : chk_rng
	function automatic logic sig(input int k);
		case (k)
			0: sig = rtt_on;
			1: sig = lnk.cke;
			2: sig = rtt_uncertain;
			3: sig = trans_win;
			4: sig = pd_active;
			5: sig = lnk.odt;
			default: sig = cmd_ready;
		endcase
	endfunction : sig
	// also counts cycles in which the controller claims certain termination
	task wait_bit(input int k, input logic v, output int c);
		c = 0;
		while (sig(k) !== v) begin
			@(negedge clk_sys);
			c++;
			if (rtt_uncertain !== 1'b1)
				gaps++;
			if (c > 3000) begin
				fail("wait ran out");
				tally_and_finish;
			end
		end
	endtask : wait_bit
	task send(input odtx_pkg::odtx_cmd_t code, input logic a12);
		cmd_code = code;
		cmd_a12 = a12;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		wait_bit(6, 1'b1, n);
		cmd_valid = 1'b0;
		if (code == odtx_pkg::CMD_MRS)
			exp_frozen = !a12;
		// the dram acts only at the link rise its sampler senses about nine cycles later
		repeat (2 * CK) @(negedge clk_sys);
	endtask : send
	// delay counted from the link odt edge to the termination change
	task odt_step(input int lo, input int hi, input string what);
		repeat (CK + $unsigned($random(seed)) % 24) @(negedge clk_sys);
		exp_rtt = !exp_rtt;
		odt_req = exp_rtt;
		wait_bit(5, exp_rtt, n);
		wait_bit(0, exp_rtt, n);
		chk_rng(n, lo, hi, what);
	endtask : odt_step
	initial begin
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		chk_bit(dll_frozen, exp_frozen, "frozen after reset");
		chk_bit(rtt_on, 1'b0, "rtt after reset");
		$display("test reset done");
		send(odtx_pkg::CMD_MRS, 1'b1);
		chk_bit(dll_frozen, exp_frozen, "dll kept running");
		repeat (3) odt_step(ODTL * CK, (ODTL + 2) * CK, "sync odt");
		pd_req = 1'b1;
		wait_bit(4, 1'b1, n);
		chk_bit(rtt_async, 1'b0, "async with running dll");
		chk_bit(trans_win, 1'b0, "window with running dll");
		odt_step(ODTL * CK, (ODTL + 2) * CK, "odt in pd with dll on");
		cmd_code = odtx_pkg::CMD_RW;
		cmd_valid = 1'b1;
		m = 0;
		repeat (5 * CK) begin
			@(negedge clk_sys);
			m += (cmd_ready === 1'b1);
		end
		cmd_valid = 1'b0;
		chk_rng(m, 0, 0, "command taken in pd");
		pd_req = 1'b0;
		wait_bit(1, 1'b1, n);
		wait_bit(2, 1'b0, n);
		$display("test running dll done");
		send(odtx_pkg::CMD_MRS, 1'b0);
		chk_bit(dll_frozen, exp_frozen, "dll frozen");
		pd_req = 1'b1;
		wait_bit(2, 1'b1, n);
		m = 0;
		for (int i = 0; i < 400 && lnk.cke !== 1'b0; i++) begin
			n = lnk.ck;
			@(negedge clk_sys);
			m += (lnk.ck === 1'b1 && n == 0);
		end
		chk_rng(m, `ODTX_TANPD - 1, `ODTX_TANPD, "lead-in ck count");
		wait_bit(3, 1'b1, n);
		wait_bit(3, 1'b0, n);
		chk_rng(n, `ODTX_TCPDED_CK * CK, (`ODTX_TCPDED_CK + 1) * CK + 1, "entry window");
		wait_bit(4, 1'b1, n);
		chk_bit(rtt_async, 1'b1, "async in frozen pd");
		chk_bit(pd_state, 1'b1, "pd state");
		repeat (3) odt_step(1, CK, "async odt");
		pd_req = 1'b0;
		wait_bit(1, 1'b1, n);
		wait_bit(2, 1'b0, n);
		chk_rng(n, (`ODTX_TXPDLL_CK - 1) * CK, (`ODTX_TXPDLL_CK + 2) * CK, "exit window");
		chk_bit(rtt_async, 1'b0, "sync after exit");
		$display("test frozen dll done");
		send(odtx_pkg::CMD_REF, 1'b0);
		pd_req = 1'b1;
		wait_bit(3, 1'b1, n);
		wait_bit(3, 1'b0, n);
		chk_rng(n, (`ODTX_TRFC_CK - `ODTX_TANPD - 3) * CK, (`ODTX_TRFC_CK + 1) * CK,
			"refresh window");
		pd_req = 1'b0;
		wait_bit(2, 1'b0, n);
		$display("test refresh done");
		pd_req = 1'b1;
		wait_bit(2, 1'b1, n);
		gaps = 0;
		wait_bit(1, 1'b0, n);
		pd_req = 1'b0;
		wait_bit(1, 1'b1, n);
		pd_req = 1'b1;
		wait_bit(1, 1'b0, n);
		chk_rng(gaps, 0, 0, "gap in short cke periods");
		pd_req = 1'b0;
		wait_bit(1, 1'b1, n);
		wait_bit(2, 1'b0, n);
		$display("test short cke done");
		tally_and_finish;
	end
endmodule : odt_async_mode_transition_test
